// *** hsc_halt_standby_controller.sv ***
// Halt and standby controller: enters one of three low-power modes on a
// halt instruction and decides which wake source ends it.
// Assumes the CPU pulses HALT_REQ on CLK, the interrupt controller drives
// levels and pending flags on CLK, and pins arrive asynchronously.
// Overview of operation
// - Halt code 10 oscillator-only, 01 full stop
// - CPU-only halt: peripherals follow idle run enables
// - Oscillator-only halt: only oscillator and clock timer
// - Full stop halts everything including the oscillator
// - Port states held in every halt mode
// - Enabled interrupt at or above mask wakes, processed
// - Masked peripheral interrupt below mask does not wake
// - Masked pin or clock timer wakes, resumes, flag kept
// - Non-maskable interrupt wakes any mode, processed
// - Peripheral interrupts wake only CPU-only halt
// - Clock timer not stop; pin interrupts all modes
// - Key wake-up releases every mode, no interrupt
// - Full stop released only after warm-up time
// - Reset releases halt, reinitialises all settings
// - Pins synchronised on CLK by two flops, restart on clock
// - Warm-up length from select, fast or slow tick
// - Restart after oscillator and memory warm-up done
// - Memory warm-up 409.6 us, applied on every full stop release
`default_nettype none
module hsc_halt_standby_controller
  import hsc_pkg::*;
#(
  parameter int WARM_MID = WARM_MID_CNT,
  parameter int WARM_LONG = WARM_LONG_CNT,
  parameter int PMEM_WARM = PMEM_WARM_CYC
)
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic HALT_REQ,
  input wire logic [2:0] CPU_MASK,
  input wire logic NMI_PIN,
  input wire logic [7:0] EXT_INT_PIN,
  input wire logic [2:0] EXT_LEVEL,
  input wire logic [7:0] KEY_WAKEUP,
  input wire logic RTC_PEND,
  input wire logic [2:0] RTC_LEVEL,
  input wire logic PERIPH_PEND,
  input wire logic [2:0] PERIPH_LEVEL,
  input wire logic SLOW_TICK,
  output logic CPU_STOP,
  output logic SYS_CLK_EN,
  output logic OSC_EN,
  output logic RTC_RUN,
  output logic PORT_HOLD,
  output logic [5:0] PERIPH_RUN,
  output logic WAKE_INT,
  output logic WAKE_RESUME
);
  timeunit 1ns;
  timeprecision 1ps;

  function automatic logic lvl_ok(input logic [2:0] lvl, input logic [2:0] mask);
    lvl_ok = (lvl >= mask);
  endfunction : lvl_ok

  function automatic logic [CNT_W-1:0] warm_len(input logic [1:0] sel);
    case (sel)
      WCS_SHORT: warm_len = CNT_W'(WARM_SHORT_CNT);
      WCS_MID: warm_len = CNT_W'(WARM_MID);
      default: warm_len = CNT_W'(WARM_LONG);
    endcase
  endfunction : warm_len

  logic [1:0] rst_sync;
  logic rst_n;
  logic [16:0] pin_s1;
  logic [16:0] pin_s2;
  logic nmi;
  logic ext_any;
  logic key_any;
  logic [1:0] halt_mode_select;
  logic [1:0] warmup_count_select;
  logic slow_sel;
  logic [5:0] idle_run_enable;
  hsc_state_t state;
  hsc_state_t next_state;
  logic take;
  logic next_take;
  logic [CNT_W-1:0] osc_cnt;
  logic [CNT_W-1:0] pmem_cnt;
  logic osc_done;
  logic pmem_done;
  logic ext_ok;
  logic rtc_ok;
  logic per_ok;
  logic wb_req;
  logic [31:0] rd_data;

  // Reset release through two flip-flops
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
      rst_sync <= 2'b00;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // Wake pins are sampled on the rising edge of CLK through two flip-flops
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1 <= 17'h0_0000;
      pin_s2 <= 17'h0_0000;
    end
    else
    begin
      pin_s1 <= {NMI_PIN, EXT_INT_PIN, KEY_WAKEUP};
      pin_s2 <= pin_s1;
    end
  end
  assign nmi = pin_s2[16];
  assign ext_any = |pin_s2[15:8];
  assign key_any = |pin_s2[7:0];

  assign ext_ok = lvl_ok(EXT_LEVEL, CPU_MASK);
  assign rtc_ok = RTC_PEND && lvl_ok(RTC_LEVEL, CPU_MASK);
  assign per_ok = PERIPH_PEND && lvl_ok(PERIPH_LEVEL, CPU_MASK);

  // Register bus: ack one cycle after the request, write at the ack edge
  assign wb_req = WB_CYC_I && WB_STB_I;

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      WB_ACK_O <= 1'b0;
    else
      WB_ACK_O <= wb_req && !WB_ACK_O;
  end

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (WB_ADR_I)
      OFS_POWER_CTRL:
      begin
        rd_data[HMS_LSB +: 2] = halt_mode_select;
        rd_data[WCS_LSB +: 2] = warmup_count_select;
      end
      OFS_CLOCK_SEL: rd_data[SLOW_SEL_BIT] = slow_sel;
      OFS_IDLE_RUN: rd_data[5:0] = idle_run_enable;
      OFS_STATUS:
      begin
        rd_data[2:0] = state;
        rd_data[ST_TAKE_BIT] = take;
      end
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      WB_DAT_O <= 32'h0000_0000;
    else if (wb_req && !WB_ACK_O && !WB_WE_I)
      WB_DAT_O <= rd_data;
  end

  // Settings return to defaults on reset
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_mode_select <= HMS_RESET;
      warmup_count_select <= WCS_RESET;
      slow_sel <= SLOW_RESET;
      idle_run_enable <= IDLE_RUN_RESET;
    end
    else if (wb_req && WB_ACK_O && WB_WE_I && WB_SEL_I[0])
    begin
      case (WB_ADR_I)
        OFS_POWER_CTRL:
        begin
          halt_mode_select <= WB_DAT_I[HMS_LSB +: 2];
          warmup_count_select <= WB_DAT_I[WCS_LSB +: 2];
        end
        OFS_CLOCK_SEL: slow_sel <= WB_DAT_I[SLOW_SEL_BIT];
        OFS_IDLE_RUN: idle_run_enable <= WB_DAT_I[5:0];
        default: ;
      endcase
    end
  end

  // Mode sequencing and wake decision
  always_comb
  begin
    next_state = state;
    next_take = take;
    case (state)
      st_run:
        if (HALT_REQ)
        begin
          case (halt_mode_select)
            MODE_OSC: next_state = st_osc_halt;
            MODE_STOP: next_state = st_stop;
            default: next_state = st_cpu_halt;
          endcase
        end
      st_cpu_halt:
        // Peripheral sources count only here; masked ones never wake
        if (nmi || key_any || ext_any || RTC_PEND || per_ok)
        begin
          next_state = st_run;
          next_take = nmi || (ext_any && ext_ok) || rtc_ok || per_ok;
        end
      st_osc_halt:
        if (nmi || key_any || ext_any || RTC_PEND)
        begin
          next_state = st_run;
          next_take = nmi || (ext_any && ext_ok) || rtc_ok;
        end
      st_stop:
        if (nmi || key_any || ext_any)
        begin
          next_state = st_warm;
          next_take = nmi || (ext_any && ext_ok);
        end
      st_warm:
        if (osc_done && pmem_done)
          next_state = st_run;
      default: next_state = st_run;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= st_run;
      take <= 1'b0;
    end
    else
    begin
      state <= next_state;
      take <= next_take;
    end
  end

  // Wake pulses, one cycle, on return to run
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      WAKE_INT <= 1'b0;
      WAKE_RESUME <= 1'b0;
    end
    else
    begin
      WAKE_INT <= (state != st_run) && (next_state == st_run) && next_take;
      WAKE_RESUME <= (state != st_run) && (next_state == st_run) && !next_take;
    end
  end

  // Warm-up counters after full stop
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      osc_cnt <= '0;
      pmem_cnt <= '0;
    end
    else if (state != st_warm)
    begin
      osc_cnt <= '0;
      pmem_cnt <= '0;
    end
    else
    begin
      if (!osc_done && (!slow_sel || SLOW_TICK))
        osc_cnt <= osc_cnt + 1'b1;
      if (!pmem_done)
        pmem_cnt <= pmem_cnt + 1'b1;
    end
  end
  assign osc_done = (osc_cnt >= warm_len(warmup_count_select));
  assign pmem_done = (pmem_cnt >= CNT_W'(PMEM_WARM));

  // Clock and unit controls per mode
  assign CPU_STOP = (state != st_run);
  assign SYS_CLK_EN = (state == st_run) || (state == st_cpu_halt);
  assign OSC_EN = (state != st_stop);
  assign RTC_RUN = (state != st_stop) && (state != st_warm);
  assign PORT_HOLD = (state != st_run);
  assign PERIPH_RUN = (state == st_run) ? 6'h3F :
                      (state == st_cpu_halt) ? idle_run_enable : 6'h00;

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  sequence s_halt_req;
    (state == st_run) && HALT_REQ;
  endsequence

  property p_enter_osc;
    s_halt_req and (halt_mode_select == MODE_OSC) |=> (state == st_osc_halt);
  endproperty
  a_enter_osc: assert property (p_enter_osc) else $error("osc halt not entered");

  property p_enter_stop;
    s_halt_req and (halt_mode_select == MODE_STOP) |=> (state == st_stop) && !OSC_EN;
  endproperty
  a_enter_stop: assert property (p_enter_stop) else $error("stop not entered");

  property p_enter_cpu;
    s_halt_req and (halt_mode_select == MODE_CPU) |=> (state == st_cpu_halt);
  endproperty
  a_enter_cpu: assert property (p_enter_cpu) else $error("cpu halt not entered");

  property p_cpu_periph;
    (state == st_cpu_halt) |-> (PERIPH_RUN == idle_run_enable) && SYS_CLK_EN;
  endproperty
  a_cpu_periph: assert property (p_cpu_periph) else $error("idle run mismatch");

  property p_osc_only;
    (state == st_osc_halt) |-> !SYS_CLK_EN && OSC_EN && RTC_RUN && (PERIPH_RUN == 6'h00);
  endproperty
  a_osc_only: assert property (p_osc_only) else $error("osc halt controls wrong");

  property p_hold;
    (state != st_run) |-> PORT_HOLD && CPU_STOP;
  endproperty
  a_hold: assert property (p_hold) else $error("ports not held");

  property p_nmi;
    ((state == st_cpu_halt) || (state == st_osc_halt)) && nmi |=> WAKE_INT && (state == st_run);
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi did not wake");

  property p_no_periph_osc;
    (state == st_osc_halt) && !nmi && !key_any && !ext_any && !RTC_PEND
      |=> (state == st_osc_halt);
  endproperty
  a_no_periph_osc: assert property (p_no_periph_osc) else $error("osc halt left");

  property p_rtc_stop;
    (state == st_stop) && !nmi && !key_any && !ext_any |=> (state == st_stop);
  endproperty
  a_rtc_stop: assert property (p_rtc_stop) else $error("stop left");

  property p_key;
    (state == st_cpu_halt) && key_any && !nmi && !ext_any && !RTC_PEND && !PERIPH_PEND
      |=> WAKE_RESUME && !WAKE_INT;
  endproperty
  a_key: assert property (p_key) else $error("key wake wrong");

  property p_masked_pin;
    (state == st_osc_halt) && ext_any && !ext_ok && !nmi && !rtc_ok |=> WAKE_RESUME;
  endproperty
  a_masked_pin: assert property (p_masked_pin) else $error("masked pin no resume");

  property p_warm_hold;
    (state == st_warm) && !(osc_done && pmem_done) |=> (state == st_warm) && !WAKE_INT;
  endproperty
  a_warm_hold: assert property (p_warm_hold) else $error("warm-up cut short");

  property p_warm_end;
    (state == st_warm) && osc_done && pmem_done |=> (state == st_run) ##0 (WAKE_INT || WAKE_RESUME);
  endproperty
  a_warm_end: assert property (p_warm_end) else $error("no restart after warm-up");

endmodule : hsc_halt_standby_controller
`default_nettype wire

// *** hsc_pkg.sv ***
// Constants shared by the halt and standby controller.
// Assumes a 200 MHz system clock and a 32-bit classic Wishbone register bus.
`default_nettype none
package hsc_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CLK_MHZ = 200;
  // Register byte offsets
  localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
  localparam logic [7:0] OFS_CLOCK_SEL = 8'h04;
  localparam logic [7:0] OFS_IDLE_RUN = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  // Field positions
  localparam int HMS_LSB = 0;
  localparam int WCS_LSB = 2;
  localparam int SLOW_SEL_BIT = 0;
  localparam int ST_TAKE_BIT = 3;
  // Halt mode select codes
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_OSC = 2'h2;
  localparam logic [1:0] MODE_CPU = 2'h3;
  // Warm-up select codes
  localparam logic [1:0] WCS_SHORT = 2'h1;
  localparam logic [1:0] WCS_MID = 2'h2;
  // Reset values
  localparam logic [1:0] HMS_RESET = 2'h3;
  localparam logic [1:0] WCS_RESET = 2'h2;
  localparam logic SLOW_RESET = 1'b0;
  localparam logic [5:0] IDLE_RUN_RESET = 6'h00;
  // Timing: warm-up counts and program-memory warm-up time
  localparam int WARM_SHORT_CNT = 256;
  localparam int WARM_MID_CNT = 16384;
  localparam int WARM_LONG_CNT = 65536;
  localparam int PMEM_WARM_NS = 409600;
  localparam int PMEM_WARM_CYC = (PMEM_WARM_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 17;
  // Maximum interrupt level; non-maskable interrupts sit at it
  localparam logic [2:0] LVL_NMI = 3'h7;
  typedef enum logic [2:0] {
    st_run,
    st_cpu_halt,
    st_osc_halt,
    st_stop,
    st_warm
  } hsc_state_t;
endpackage : hsc_pkg
`default_nettype wire

// *** hsc_cpu_irq_model.sv ***
// Model of the CPU core and interrupt controller beside the controller.
// Assumes the bench calls its tasks; all activity on the shared clock.
`default_nettype none
module hsc_cpu_irq_model
(
  input wire logic CLK,
  input wire logic NRST,
  input wire logic WAKE_INT,
  input wire logic WAKE_RESUME,
  output logic HALT_REQ,
  output logic [4:0] PEND
);
  timeunit 1ns;
  timeprecision 1ps;
  // PEND order: nmi pin, ext pin, key pin, clock timer, peripheral
  logic halt_q = 1'b0;
  logic clr = 1'b0;
  logic [4:0] set_m = 5'h00;
  assign HALT_REQ = halt_q;
  // Only this process owns PEND; tasks post one-cycle requests to it
  always @(posedge CLK or negedge NRST)
    if (!NRST)
      PEND <= 5'h00;
    else if (clr || WAKE_INT)
      PEND <= 5'h00;
    else if (WAKE_RESUME)
      PEND <= PEND & 5'h02;
    else
      PEND <= PEND | set_m;
  task automatic halt;
    @(posedge CLK);
    halt_q <= 1'b1;
    @(posedge CLK);
    halt_q <= 1'b0;
  endtask : halt
  task automatic raise(input logic [4:0] m);
    @(posedge CLK);
    set_m <= m;
    @(posedge CLK);
    set_m <= 5'h00;
  endtask : raise
  task automatic clear;
    @(posedge CLK);
    clr <= 1'b1;
    @(posedge CLK);
    clr <= 1'b0;
  endtask : clear
endmodule : hsc_cpu_irq_model
`default_nettype wire

// *** tb_halt_standby_controller.sv ***
// Bench for the halt and standby controller: register access, entry to
// each halt mode and every wake source. Assumes shortened warm-up counts.
`default_nettype none
module tb_halt_standby_controller import hsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, cyc, stb, we, halt, tick, ack;
  logic [3:0] sel;
  logic [6:0] ext_hi, key_hi;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [4:0] pend;
  logic [2:0] mask, elvl, rlvl, plvl;
  logic cpu_stop, sys_en, osc_en, rtc_run, hold, wint, wres, gi, gr;
  logic [5:0] prun;
  int fail_count, n_tests, n, tc;
  int ex[4] = '{256, 40, 30, 76};
  logic [1:0] wc[4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  wire [10:0] mo = {cpu_stop, sys_en, osc_en, rtc_run, hold, prun};
  hsc_halt_standby_controller #(.WARM_MID(40), .WARM_LONG(20), .PMEM_WARM(30)) dut
  (
    .CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .HALT_REQ(halt), .CPU_MASK(mask), .NMI_PIN(pend[4]), .EXT_INT_PIN({ext_hi, pend[3]}),
    .EXT_LEVEL(elvl), .KEY_WAKEUP({key_hi, pend[2]}), .RTC_PEND(pend[1]),
    .RTC_LEVEL(rlvl), .PERIPH_PEND(pend[0]), .PERIPH_LEVEL(plvl), .SLOW_TICK(tick),
    .CPU_STOP(cpu_stop), .SYS_CLK_EN(sys_en), .OSC_EN(osc_en), .RTC_RUN(rtc_run),
    .PORT_HOLD(hold), .PERIPH_RUN(prun), .WAKE_INT(wint), .WAKE_RESUME(wres)
  );
  hsc_cpu_irq_model m
  (
    .CLK(clk), .NRST(nrst), .WAKE_INT(wint), .WAKE_RESUME(wres), .HALT_REQ(halt),
    .PEND(pend)
  );
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Slow clock tick every fourth cycle
  always @(posedge clk)
  begin
    tc <= tc + 1;
    tick <= (tc % 4 == 3);
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= {24'h00_0000, d};
    @(posedge clk);
    // Wait for the answer; only the watchdog ends a hung access
    while (ack !== 1'b1)
    begin
      @(posedge clk);
      k++;
    end
    chk("ack latency", 1, k);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'h1, q);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, 4'h1, q);
    chk(nm, {24'h00_0000, e}, q);
  endtask : rchk
  task automatic wait_run;
    n = 0;
    gi = 1'b0;
    gr = 1'b0;
    do
    begin
      @(posedge clk);
      n++;
      gi |= wint;
      gr |= wres;
    end
    while (!(sys_en === 1'b1 && cpu_stop === 1'b0) && n < 2000);
    chk("wake seen", 1, n < 2000);
  endtask : wait_run
  task automatic still(input string nm);
    repeat (10) @(posedge clk);
    chk(nm, 1, cpu_stop);
  endtask : still
  task automatic enter(input logic [7:0] pc, input logic [10:0] e);
    wreg(OFS_POWER_CTRL, pc);
    m.halt();
    repeat (2) @(posedge clk);
    chk("mode outputs", e, mo);
  endtask : enter
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    #(5 * 20000);
    fail_count++;
    print_verdict();
  end
  initial
  begin
    {nrst, cyc, stb, we} = '0;
    {adr, wdat, mask, elvl, rlvl, plvl, sel, ext_hi, key_hi} = '0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("power reset", OFS_POWER_CTRL, 8'h0B);
    rchk("clock sel reset", OFS_CLOCK_SEL, 8'h00);
    rchk("idle reset", OFS_IDLE_RUN, 8'h00);
    rchk("unmapped", 8'h10, 8'h00);
    wb(1'b1, OFS_IDLE_RUN, 8'h3F, 4'h0, q);
    rchk("sel0 write ignored", OFS_IDLE_RUN, 8'h00);
    chk("run outputs", 11'h3BF, mo);
    $display("test reset done");
    wreg(OFS_IDLE_RUN, 8'h15);
    mask <= 3'h4;
    plvl <= 3'h3;
    enter(8'h0B, 11'h7D5);
    m.raise(5'h01);
    still("below mask");
    plvl <= 3'h5;
    wait_run();
    chk("cpu halt wake", 1, gi);
    rchk("status", OFS_STATUS, 8'h08);
    $display("test cpu halt done");
    plvl <= 3'h7;
    enter(8'h0A, 11'h5C0);
    m.raise(5'h01);
    still("peripheral in osc");
    rlvl <= 3'h1;
    m.raise(5'h02);
    wait_run();
    chk("masked resume", 2'b01, {gi, gr});
    @(posedge clk);
    chk("flag kept", 1, pend[1]);
    m.clear();
    mask <= 3'h7;
    enter(8'h0A, 11'h5C0);
    m.raise(5'h10);
    wait_run();
    chk("nmi wake", 1, gi);
    elvl <= 3'h2;
    enter(8'h0A, 11'h5C0);
    ext_hi <= 7'h01;
    wait_run();
    chk("masked pin resume", 2'b01, {gi, gr});
    ext_hi <= 7'h00;
    $display("test osc halt done");
    mask <= 3'h1;
    elvl <= 3'h3;
    for (int i = 0; i < 4; i++)
    begin
      wreg(OFS_CLOCK_SEL, {7'h00, i == 3});
      enter({4'h0, wc[i], 2'h1}, 11'h440);
      m.raise(5'h02);
      still("clock timer in stop");
      m.raise(5'h08);
      wait_run();
      chk("warm time", 1, n >= ex[i] && n <= ex[i] + 12);
      chk("pin wake", 1, gi);
      m.clear();
    end
    wreg(OFS_CLOCK_SEL, 8'h00);
    enter(8'h0D, 11'h440);
    m.raise(5'h04);
    wait_run();
    chk("key wake", 2'b01, {gi, gr});
    enter(8'h0B, 11'h7D5);
    key_hi <= 7'h40;
    wait_run();
    chk("key cpu wake", 2'b01, {gi, gr});
    key_hi <= 7'h00;
    $display("test stop done");
    enter(8'h0D, 11'h440);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("reset release", 11'h3BF, mo);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("power reinit", OFS_POWER_CTRL, 8'h0B);
    rchk("idle reinit", OFS_IDLE_RUN, 8'h00);
    $display("test reset release done");
    print_verdict();
  end
endmodule : tb_halt_standby_controller
`default_nettype wire
